//--- cldc_cfg.svh
`ifndef CLDC_CFG_SVH
`define CLDC_CFG_SVH
`define CLDC_NUM_CHANNELS 20
`define CLDC_NUM_DIAG 8
`define CLDC_SEL_WIDTH 5
`define CLDC_SEL_CYCLE 5'h1f
`define CLDC_SEL_LAST_CHAN 5'h13
`define CLDC_SAMPLE_WIDTH 12
`define CLDC_RES_LOG2_MIN 5'h04
`define CLDC_RES_LOG2_MAX 5'h10
`define CLDC_RES_LOG2_RESET 5'h04
`define CLDC_DIAG_SEL_RESET 5'h00
`define CLDC_ABS_LOW_RESET 12'h400
`define CLDC_ABS_HIGH_RESET 12'h800
`endif

//--- cldc_pkg.sv
package cldc_pkg;
  typedef enum logic [1:0] {
    CLDC_REF_ABSOLUTE = 2'h0,
    CLDC_REF_BATTERY_A = 2'h1,
    CLDC_REF_BATTERY_B = 2'h2
  } cldc_ref_t;
  typedef enum logic [1:0] {
    CLDC_MODE_FOLLOWER = 2'h0,
    CLDC_MODE_LOCAL = 2'h1,
    CLDC_MODE_SYSTEM = 2'h2
  } cldc_mode_t;
endpackage : cldc_pkg

//--- cldc_channel_level_diag.sv
`timescale 1ns/10ps
`default_nettype none
`include "cldc_cfg.svh"
module cldc_channel_level_diag
  import cldc_pkg::*;
#(
  parameter int NUM_CHANNELS = `CLDC_NUM_CHANNELS,
  parameter int NUM_DIAG = `CLDC_NUM_DIAG,
  parameter int SAMPLE_WIDTH = `CLDC_SAMPLE_WIDTH
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic speed_generator_present,
  input wire logic [1:0] generator_mode_request,
  input wire logic [4:0] resolution_log2_request,
  input wire logic backplane_angle_tick,
  input wire logic local_angle_tick,
  input wire logic [NUM_CHANNELS-1:0] channel_measure_enable,
  input wire logic [NUM_CHANNELS*2-1:0] threshold_reference,
  input wire logic [NUM_CHANNELS*SAMPLE_WIDTH-1:0] abs_low_threshold,
  input wire logic [NUM_CHANNELS*SAMPLE_WIDTH-1:0] abs_high_threshold,
  input wire logic [NUM_CHANNELS*SAMPLE_WIDTH-1:0] rise_fall_low_threshold,
  input wire logic [NUM_CHANNELS*SAMPLE_WIDTH-1:0] rise_fall_high_threshold,
  input wire logic [NUM_CHANNELS*SAMPLE_WIDTH-1:0] channel_sample,
  input wire logic [SAMPLE_WIDTH-1:0] battery_a_reference,
  input wire logic [SAMPLE_WIDTH-1:0] battery_b_reference,
  input wire logic [NUM_DIAG*5-1:0] diag_select,
  output logic [31:0] channel_level_word,
  output logic [NUM_CHANNELS-1:0] channel_measure_active,
  output logic [NUM_CHANNELS-1:0] rise_fall_above_high,
  output logic [NUM_CHANNELS-1:0] rise_fall_below_low,
  output logic [NUM_DIAG-1:0] diag_out,
  output logic crank_angle_clock,
  output logic cycle_indicator,
  output logic [1:0] generator_mode,
  output logic [4:0] resolution_log2,
  output logic [15:0] angle_tick_count
);
  initial begin
    if (NUM_CHANNELS < 1 || NUM_CHANNELS > 20 || NUM_DIAG < 1 || SAMPLE_WIDTH < 2)
      $error("cldc: unsupported parameter values");
  end

  function automatic logic [SAMPLE_WIDTH-1:0] ch_field(
    input logic [NUM_CHANNELS*SAMPLE_WIDTH-1:0] bus, input int idx);
    ch_field = bus[idx*SAMPLE_WIDTH +: SAMPLE_WIDTH];
  endfunction : ch_field

  function automatic logic [SAMPLE_WIDTH-1:0] third(input logic [SAMPLE_WIDTH-1:0] v);
    third = SAMPLE_WIDTH'(v / 3);
  endfunction : third

  logic [NUM_CHANNELS-1:0] level_reg, level_next;
  logic [NUM_CHANNELS*SAMPLE_WIDTH-1:0] low_reg, low_next, high_reg, high_next;
  logic [NUM_CHANNELS-1:0] enable_reg, enable_next, rf_hi_reg, rf_hi_next, rf_lo_reg, rf_lo_next;
  logic [NUM_DIAG-1:0] diag_reg, diag_next;
  logic [1:0] mode_reg, mode_next;
  logic [4:0] res_reg, res_next;
  logic [15:0] tick_reg, tick_next;
  logic [15:0] tick_last;
  logic tick_in, cyc_reg, cyc_next, cac_reg, cac_next;

  always_comb begin
    level_next = level_reg;
    low_next = low_reg;
    high_next = high_reg;
    rf_hi_next = rf_hi_reg;
    rf_lo_next = rf_lo_reg;
    enable_next = channel_measure_enable;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      case (cldc_ref_t'(threshold_reference[i*2 +: 2]))
        CLDC_REF_BATTERY_A: begin
          low_next[i*SAMPLE_WIDTH +: SAMPLE_WIDTH] = third(battery_a_reference);
          high_next[i*SAMPLE_WIDTH +: SAMPLE_WIDTH] =
            SAMPLE_WIDTH'({1'b0, battery_a_reference} - {1'b0, third(battery_a_reference)});
        end
        CLDC_REF_BATTERY_B: begin
          low_next[i*SAMPLE_WIDTH +: SAMPLE_WIDTH] = third(battery_b_reference);
          high_next[i*SAMPLE_WIDTH +: SAMPLE_WIDTH] =
            SAMPLE_WIDTH'({1'b0, battery_b_reference} - {1'b0, third(battery_b_reference)});
        end
        CLDC_REF_ABSOLUTE: begin
          low_next[i*SAMPLE_WIDTH +: SAMPLE_WIDTH] = ch_field(abs_low_threshold, i);
          high_next[i*SAMPLE_WIDTH +: SAMPLE_WIDTH] = ch_field(abs_high_threshold, i);
        end
        default: begin
        end
      endcase
      if (ch_field(channel_sample, i) > ch_field(high_reg, i))
        level_next[i] = 1'b1;
      else if (ch_field(channel_sample, i) < ch_field(low_reg, i))
        level_next[i] = 1'b0;
      rf_hi_next[i] = ch_field(channel_sample, i) > ch_field(rise_fall_high_threshold, i);
      rf_lo_next[i] = ch_field(channel_sample, i) < ch_field(rise_fall_low_threshold, i);
    end
  end

  always_comb begin
    mode_next = speed_generator_present ? generator_mode_request : CLDC_MODE_FOLLOWER;
    if (mode_next == 2'h3)
      mode_next = mode_reg;
    res_next = res_reg;
    if (resolution_log2_request >= `CLDC_RES_LOG2_MIN &&
        resolution_log2_request <= `CLDC_RES_LOG2_MAX)
      res_next = resolution_log2_request;
    tick_in = (mode_reg == CLDC_MODE_FOLLOWER) ? backplane_angle_tick : local_angle_tick;
    tick_last = 16'((17'h1 << res_reg) - 17'h1);
    tick_next = tick_reg;
    cyc_next = 1'b0;
    cac_next = tick_in;
    if (tick_in) begin
      tick_next = (tick_reg >= tick_last) ? 16'h0000 : 16'(tick_reg + 16'h1);
      cyc_next = (tick_reg >= tick_last);
    end
    for (int d = 0; d < NUM_DIAG; d++) begin
      if (diag_select[d*5 +: 5] == `CLDC_SEL_CYCLE)
        diag_next[d] = cyc_next;
      else if (diag_select[d*5 +: 5] < 5'(NUM_CHANNELS))
        diag_next[d] = level_next[diag_select[d*5 +: 5]];
      else
        diag_next[d] = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      level_reg <= '0;
      low_reg <= {NUM_CHANNELS{`CLDC_ABS_LOW_RESET}};
      high_reg <= {NUM_CHANNELS{`CLDC_ABS_HIGH_RESET}};
      enable_reg <= '0;
      rf_hi_reg <= '0;
      rf_lo_reg <= '0;
      diag_reg <= '0;
      mode_reg <= CLDC_MODE_FOLLOWER;
      res_reg <= `CLDC_RES_LOG2_RESET;
      tick_reg <= '0;
      cyc_reg <= 1'b0;
      cac_reg <= 1'b0;
    end else if (clk_en) begin
      level_reg <= level_next;
      low_reg <= low_next;
      high_reg <= high_next;
      enable_reg <= enable_next;
      rf_hi_reg <= rf_hi_next;
      rf_lo_reg <= rf_lo_next;
      diag_reg <= diag_next;
      mode_reg <= mode_next;
      res_reg <= res_next;
      tick_reg <= tick_next;
      cyc_reg <= cyc_next;
      cac_reg <= cac_next;
    end
  end

  assign channel_level_word = 32'(level_reg);
  assign channel_measure_active = enable_reg;
  assign rise_fall_above_high = rf_hi_reg;
  assign rise_fall_below_low = rf_lo_reg;
  assign diag_out = diag_reg;
  assign crank_angle_clock = cac_reg;
  assign cycle_indicator = cyc_reg;
  assign generator_mode = mode_reg;
  assign resolution_log2 = res_reg;
  assign angle_tick_count = tick_reg;

  a_level_zero_top: assert property (@(posedge clk_sys) disable iff (!reset_n)
    channel_level_word[31:20] == 12'h000) else $error("level word upper bits set");
  a_follower_only: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (!speed_generator_present && clk_en) |=> generator_mode == CLDC_MODE_FOLLOWER)
    else $error("generator mode without speed generator");
  a_res_range: assert property (@(posedge clk_sys) disable iff (!reset_n)
    resolution_log2 >= `CLDC_RES_LOG2_MIN && resolution_log2 <= `CLDC_RES_LOG2_MAX)
    else $error("resolution out of range");
  a_cycle_single: assert property (@(posedge clk_sys) disable iff (!reset_n)
    cycle_indicator |-> angle_tick_count == 16'h0000 && crank_angle_clock)
    else $error("cycle indicator off cycle start");
  a_cycle_wrap: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && tick_in && tick_reg >= tick_last) |=> cycle_indicator)
    else $error("cycle indicator missed");
  a_enable_follow: assert property (@(posedge clk_sys) disable iff (!reset_n)
    clk_en |=> channel_measure_active == $past(channel_measure_enable))
    else $error("enable not applied");
  a_hyst_high: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && ch_field(channel_sample, 0) > ch_field(high_reg, 0)) |=> channel_level_word[0])
    else $error("level not high above upper");
  a_hyst_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && ch_field(channel_sample, 0) <= ch_field(high_reg, 0) &&
     ch_field(channel_sample, 0) >= ch_field(low_reg, 0)) |=> $stable(channel_level_word[0]))
    else $error("level changed inside hysteresis");
  a_diag_route: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (clk_en && diag_select[4:0] < 5'(NUM_CHANNELS)) |=> diag_out[0] == level_reg[$past(diag_select[4:0])])
    else $error("diagnostic routing wrong");
endmodule : cldc_channel_level_diag
`default_nettype wire

//--- cldc_target_model.sv
`timescale 1ns/10ps
`default_nettype none
module cldc_target_model (
  input wire logic clk_sys,
  input wire logic run,
  input wire logic [31:0] channel_level_word,
  output logic backplane_angle_tick,
  output logic [31:0] level_snapshot
);
  logic [1:0] div_reg = 2'h0;
  initial backplane_angle_tick = 1'b0;
  initial level_snapshot = 32'h0;
  // backplane tick every fourth cycle while running, still otherwise
  always @(posedge clk_sys) begin
    div_reg <= run ? div_reg + 2'h1 : 2'h0;
    backplane_angle_tick <= run && (div_reg == 2'h3);
    level_snapshot <= channel_level_word; // periodic level read
  end
endmodule : cldc_target_model
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cldc_pkg::*;
  logic clk_sys = 1'b0, reset_n = 1'b0, run = 1'b0, sgp = 1'b0, clk_en = 1'b1, tick, cyc;
  logic [1:0] mode_req = 2'h1, gmode;
  logic [4:0] res_req = 5'h04, res;
  logic [19:0] en = 20'h0, act, above, below;
  logic [39:0] tref = 40'h0, dsel = 40'h0;
  logic [239:0] samp = '0, rfl = {20{12'h200}}, rfh = {20{12'h700}};
  logic [11:0] bat_a = 12'h900, bat_b = 12'h300;
  logic [31:0] lvl, snap;
  logic [7:0] diag, ed;
  logic [15:0] tcnt;
  int bad_count = 0, n_compared = 0, pc = 0, pd = 0;
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    pc += (cyc === 1'b1);
    pd += (diag[0] === 1'b1);
  end
  cldc_target_model partner (.clk_sys(clk_sys), .run(run), .channel_level_word(lvl),
    .backplane_angle_tick(tick), .level_snapshot(snap));
  cldc_channel_level_diag dut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .speed_generator_present(sgp), .generator_mode_request(mode_req),
    .resolution_log2_request(res_req), .backplane_angle_tick(tick), .local_angle_tick(1'b0),
    .channel_measure_enable(en), .threshold_reference(tref),
    .abs_low_threshold({20{12'h400}}), .abs_high_threshold({20{12'h800}}),
    .rise_fall_low_threshold(rfl), .rise_fall_high_threshold(rfh), .channel_sample(samp),
    .battery_a_reference(bat_a), .battery_b_reference(bat_b), .diag_select(dsel),
    .channel_level_word(lvl), .channel_measure_active(act), .rise_fall_above_high(above),
    .rise_fall_below_low(below), .diag_out(diag), .crank_angle_clock(), .cycle_indicator(cyc),
    .generator_mode(gmode), .resolution_log2(res), .angle_tick_count(tcnt));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic look(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : look
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  initial begin
    #200us;
    bad_count++;
    results();
  end
  initial begin
    look(8);
    chk({lvl[23:0], 3'h0, res, 14'h0, gmode, tcnt}, 64'h4_0000_0000);
    @(posedge clk_sys) reset_n <= 1'b1;
    for (int i = 0; i < 20; i++) samp[i*12+:12] <= (i % 2) ? 12'h100 : 12'hfff;
    look(4);
    chk(snap, 32'h0005_5555);
    chk(above, 32'h5_5555);
    for (int s = 0; s < 20; s++) begin
      @(posedge clk_sys);
      for (int d = 0; d < 8; d++) begin
        dsel[d*5+:5] <= 5'((s + d) % 20);
        ed[d] = ((s + d) % 2) == 0;
      end
      look(3);
      chk(diag, ed);
    end
    $display("levels and diag done");
    @(posedge clk_sys) en <= 20'habcde;
    look(3);
    chk(act, 32'habcde);
    @(posedge clk_sys) en <= 20'h54321;
    look(3);
    chk(act, 32'h54321);
    clk_en <= 1'b0;
    en <= 20'h0f0f0;
    look(3);
    chk(act, 32'h54321);
    clk_en <= 1'b1;
    look(2);
    chk(act, 32'h0f0f0);
    @(posedge clk_sys) samp <= {20{12'h100}};
    look(4);
    chk(lvl, 32'h0);
    tref <= {20{2'h1}};
    samp <= {20{12'h650}};
    look(4);
    chk(lvl, 32'hfffff);
    tref <= {20{2'h2}};
    look(3);
    samp <= {20{12'h150}};
    look(4);
    chk(lvl, 32'hfffff);
    samp <= {20{12'h0f0}};
    look(4);
    chk({lvl, below}, 64'hfffff);
    $display("thresholds done");
    dsel <= {8{5'h1f}};
    pc = 0;
    pd = 0;
    run <= 1'b1;
    look(140);
    chk({pc, pd}, {32'd2, 32'd2});
    chk(gmode, 32'h0);
    run <= 1'b0;
    res_req <= 5'h05;
    look(3);
    chk(res, 32'h5);
    res_req <= 5'h11;
    look(3);
    chk(res, 32'h5);
    res_req <= 5'h10;
    look(3);
    chk(res, 32'h10);
    sgp <= 1'b1;
    look(3);
    chk(gmode, 32'h1);
    mode_req <= 2'h3;
    look(3);
    chk(gmode, 32'h1);
    sgp <= 1'b0;
    look(3);
    chk(gmode, 32'h0);
    $display("angle clock done");
    results();
  end
endmodule : tb_top
`default_nettype wire
